// ---- rtl/ttc_pkg.sv ----
// Types shared by the triple timer/counter block.
// Assumes the constants of ttc_regs.svh for field positions.
package ttc_pkg;
  typedef enum logic [1:0] {
    TTC_M13,
    TTC_M16,
    TTC_M8R,
    TTC_MSPLIT
  } ttc_mode_e;

  // One nibble of the shared mode register
  typedef struct packed {
    logic      gate;
    logic      cntSel;
    ttc_mode_e mode;
  } ttc_tcfg_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic        ovf;
    logic        ovfHi;
  } ttc_step_s;

  // Synchronous pin inputs
  typedef struct packed {
    logic firstGatePin;
    logic secondGatePin;
    logic firstCountPin;
    logic secondCountPin;
    logic thirdTimerTriggerPin;
    logic clkPinIn;
  } ttc_pins_s;
endpackage

// ---- rtl/ttc_regs.svh ----
// Register offsets, field positions, reset values and prescale counts of the timer block.
// Assumes a 32-bit AHB-Lite slave window; only haddr[7:0] is decoded.
`ifndef TTC_REGS_SVH
`define TTC_REGS_SVH
`define TTC_A_MODE      8'h00
`define TTC_A_CTRL      8'h04
`define TTC_A_T3CTL     8'h08
`define TTC_A_T3AUX     8'h0C
`define TTC_A_C1L       8'h10
`define TTC_A_C1H       8'h14
`define TTC_A_C2L       8'h18
`define TTC_A_C2H       8'h1C
`define TTC_A_C3L       8'h20
`define TTC_A_C3H       8'h24
`define TTC_A_RLDL      8'h28
`define TTC_A_RLDH      8'h2C
`define TTC_A_STAT      8'h30
`define TTC_A_MASK      8'h34
`define TTC_CTRL_RUN1   0
`define TTC_CTRL_RUN2   1
`define TTC_CTRL_SIX    4
`define TTC_T3_CAPSEL   0
`define TTC_T3_CNTSEL   1
`define TTC_T3_RUN      2
`define TTC_T3_EXTEN    3
`define TTC_T3_TXBAUD   4
`define TTC_T3_RXBAUD   5
`define TTC_AUX_CLKOE   1
`define TTC_ST_OVF1     0
`define TTC_ST_OVF2     1
`define TTC_ST_OVF3     2
`define TTC_ST_TRIG3    3
`define TTC_ST_SPLIT    4
`define TTC_ST_W        5
`define TTC_RST_BYTE    8'h00
`define TTC_RST_CNT     16'h0000
`define TTC_CNT_MAX     16'hFFFF
`define TTC_PRE_12      4'hB
`define TTC_PRE_6       4'h5
`endif

// ---- rtl/ttc_top.sv ----
// Three 16-bit timer/counters with clock output, reached over AHB-Lite.
// Assumes one slave on the bus (hreadyout is hready) and pins synchronous to mclk.
// Functional notes
// R1: three 16-bit counters as byte pairs
// R2: low mode nibble sets first timer
// R3: high nibble sets second; mode 3 stops
// R4: first gate pin falling toggles when gated
// R5: second gate pin falling toggles when gated
// R6: third control decodes reload/capture/counter/baud
// R7: software sets third run bit separately
// R8: no trigger: action only on overflow
// R9: trigger falling edge also acts, not baud
// R10: square wave on clock pin
// R11: clock pin counts events for third
// R12: software configures clock output bits
// R13: clock frequency osc over n(65536-reload)
// R14: reload is high:low unsigned word
// R15: clock output overflows raise no flag
// R16: baud and clock output together
// R17: overflow sets flag; auto-reload reloads
// R18: counters count falling input edges
// R19: 13-bit mode overflows after 8192
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "ttc_regs.svh"

module ttc_top (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Pins
  input  ttc_pkg::ttc_pins_s     pins,
  output logic                   clkPinOut,
  output logic                   clkPinOe,
  // Baud ticks and interrupt
  output logic                   baudTxTick,
  output logic                   baudRxTick,
  output logic                   irqOut
);
  import ttc_pkg::*;

  logic [7:0]           modeReg_q, ctrlReg_q, t3Ctl_q, t3Aux_q, addr_q;
  logic [15:0]          c1_q, c2_q, c3_q, rcap_q;
  logic [`TTC_ST_W-1:0] stat_q, mask_q, statSet;
  logic [31:0]          rdData_q, rdMux;
  logic [5:0]           pinPrev_q, pinFall;
  logic [3:0]           presc_q;
  logic                 wrPend_q, rdWait_q, accept, machTick, halfTick;
  logic                 gate1On_q, gate2On_q, clkOut_q, baudTx_q, baudRx_q;
  logic                 run1, run2, tick1, tick2;
  logic                 t3Baud, t3Fast, t3Cap, t3Inc, t3Ovf, t3Trig;
  ttc_pins_s            fall;
  ttc_tcfg_s            cfg1, cfg2;
  ttc_step_s            st1, st2;
  // Count step for the first two timers in all four modes
  function automatic ttc_step_s stepTmr(input logic [15:0] c, input ttc_mode_e m,
                                        input logic incLo, input logic incHi);
    ttc_step_s  r;
    logic [13:0] v13;
    logic [16:0] v16;
    logic [8:0]  lo9;
    logic [8:0]  hi9;
    r   = '{cnt: c, ovf: 1'b0, ovfHi: 1'b0};
    v13 = {1'b0, c[15:8], c[4:0]} + 14'h0001;
    v16 = {1'b0, c} + 17'h00001;
    lo9 = {1'b0, c[7:0]} + 9'h001;
    hi9 = {1'b0, c[15:8]} + 9'h001;
    case (m)
      TTC_M13: begin
        r.cnt = incLo ? {v13[12:5], c[7:5], v13[4:0]} : c; // R19
        r.ovf = incLo & v13[13]; // R19
      end
      TTC_M16: begin
        r.cnt = incLo ? v16[15:0] : c;
        r.ovf = incLo & v16[16];
      end
      TTC_M8R: begin
        r.cnt[7:0] = !incLo ? c[7:0] : (lo9[8] ? c[15:8] : lo9[7:0]); // R17
        r.ovf      = incLo & lo9[8];
      end
      TTC_MSPLIT: begin
        if (incLo) begin
          r.cnt[7:0] = lo9[7:0];
          r.ovf      = lo9[8];
        end
        if (incHi) begin
          r.cnt[15:8] = hi9[7:0];
          r.ovfHi     = hi9[8];
        end
      end
      default: r = '{cnt: c, ovf: 1'b0, ovfHi: 1'b0};
    endcase
    return r;
  endfunction

  // Bus slave: writes take zero waits, reads one wait so hrdata comes from a flop
  assign accept    = hsel & htrans[1] & hready;
  assign hreadyout = ~rdWait_q;
  assign hresp     = 1'b0;
  assign hrdata    = rdData_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addr_q   <= `TTC_RST_BYTE;
      wrPend_q <= 1'b0;
      rdWait_q <= 1'b0;
    end else begin
      rdWait_q <= accept & ~hwrite;
      wrPend_q <= accept & hwrite;
      if (accept) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  function automatic logic wrAt(input logic [7:0] a);
    return wrPend_q && (addr_q == a);
  endfunction

  always_comb begin
    rdMux = 32'h0000_0000;
    case (addr_q)
      `TTC_A_MODE:  rdMux[7:0] = modeReg_q;
      `TTC_A_CTRL:  rdMux[7:0] = ctrlReg_q;
      `TTC_A_T3CTL: rdMux[7:0] = t3Ctl_q;
      `TTC_A_T3AUX: rdMux[7:0] = t3Aux_q;
      `TTC_A_C1L:   rdMux[7:0] = c1_q[7:0]; // R1
      `TTC_A_C1H:   rdMux[7:0] = c1_q[15:8];
      `TTC_A_C2L:   rdMux[7:0] = c2_q[7:0];
      `TTC_A_C2H:   rdMux[7:0] = c2_q[15:8];
      `TTC_A_C3L:   rdMux[7:0] = c3_q[7:0];
      `TTC_A_C3H:   rdMux[7:0] = c3_q[15:8];
      `TTC_A_RLDL:  rdMux[7:0] = rcap_q[7:0];
      `TTC_A_RLDH:  rdMux[7:0] = rcap_q[15:8];
      `TTC_A_STAT:  rdMux[`TTC_ST_W-1:0] = stat_q;
      `TTC_A_MASK:  rdMux[`TTC_ST_W-1:0] = mask_q;
      default:      rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdData_q <= 32'h0000_0000;
    end else if (rdWait_q) begin
      rdData_q <= rdMux;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      modeReg_q <= `TTC_RST_BYTE;
      ctrlReg_q <= `TTC_RST_BYTE;
      t3Ctl_q   <= `TTC_RST_BYTE;
      t3Aux_q   <= `TTC_RST_BYTE;
      mask_q    <= '0;
    end else begin
      if (wrAt(`TTC_A_MODE)) modeReg_q <= hwdata[7:0]; // R2 R3
      if (wrAt(`TTC_A_CTRL)) ctrlReg_q <= hwdata[7:0];
      if (wrAt(`TTC_A_T3CTL)) t3Ctl_q <= hwdata[7:0]; // R6
      if (wrAt(`TTC_A_T3AUX)) t3Aux_q <= hwdata[7:0];
      if (wrAt(`TTC_A_MASK)) mask_q <= hwdata[`TTC_ST_W-1:0];
    end
  end

  // Pin edges and machine-cycle prescaler
  assign pinFall = pinPrev_q & ~pins;
  assign fall    = ttc_pins_s'(pinFall);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pinPrev_q <= '0;
    end else begin
      pinPrev_q <= pins;
    end
  end

  assign machTick = presc_q == (ctrlReg_q[`TTC_CTRL_SIX] ? `TTC_PRE_6 : `TTC_PRE_12);
  // Half-rate tick feeds clock output and baud: every 2 clocks, or every clock in 6-clock mode
  assign halfTick = ctrlReg_q[`TTC_CTRL_SIX] | presc_q[0]; // R13

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      presc_q <= 4'h0;
    end else begin
      presc_q <= machTick ? 4'h0 : presc_q + 4'h1;
    end
  end

  // First and second timers
  assign cfg1  = ttc_tcfg_s'(modeReg_q[3:0]);
  assign cfg2  = ttc_tcfg_s'(modeReg_q[7:4]);
  assign run1  = ctrlReg_q[`TTC_CTRL_RUN1] & (~cfg1.gate | gate1On_q); // R4
  assign run2  = ctrlReg_q[`TTC_CTRL_RUN2] & (~cfg2.gate | gate2On_q); // R5
  assign tick1 = cfg1.cntSel ? fall.firstCountPin : machTick; // R18
  // Counter use of split mode is not offered on the second timer
  assign tick2 = cfg2.cntSel ? fall.secondCountPin : machTick; // R18
  assign st1   = stepTmr(c1_q, cfg1.mode, run1 & tick1,
                         ctrlReg_q[`TTC_CTRL_RUN2] & machTick);
  assign st2   = stepTmr(c2_q, cfg2.mode, run2 & tick2 & (cfg2.mode != TTC_MSPLIT),
                         1'b0); // R3

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gate1On_q <= 1'b0;
      gate2On_q <= 1'b0;
    end else begin
      if (!ctrlReg_q[`TTC_CTRL_RUN1]) gate1On_q <= 1'b0;
      else if (cfg1.gate && fall.firstGatePin) gate1On_q <= ~gate1On_q; // R4
      if (!ctrlReg_q[`TTC_CTRL_RUN2]) gate2On_q <= 1'b0;
      else if (cfg2.gate && fall.secondGatePin) gate2On_q <= ~gate2On_q; // R5
    end
  end

  // A software write to a count byte wins over the hardware step
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      c1_q <= `TTC_RST_CNT;
    end else if (wrAt(`TTC_A_C1L)) begin
      c1_q <= {c1_q[15:8], hwdata[7:0]}; // R1
    end else if (wrAt(`TTC_A_C1H)) begin
      c1_q <= {hwdata[7:0], c1_q[7:0]};
    end else begin
      c1_q <= st1.cnt;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      c2_q <= `TTC_RST_CNT;
    end else if (wrAt(`TTC_A_C2L)) begin
      c2_q <= {c2_q[15:8], hwdata[7:0]};
    end else if (wrAt(`TTC_A_C2H)) begin
      c2_q <= {hwdata[7:0], c2_q[7:0]};
    end else begin
      c2_q <= st2.cnt;
    end
  end

  // Third timer
  assign t3Baud = t3Ctl_q[`TTC_T3_TXBAUD] | t3Ctl_q[`TTC_T3_RXBAUD]; // R6
  assign t3Fast = t3Baud | t3Aux_q[`TTC_AUX_CLKOE]; // R16
  assign t3Cap  = t3Ctl_q[`TTC_T3_CAPSEL] & ~t3Fast;
  assign t3Inc  = t3Ctl_q[`TTC_T3_RUN] & (t3Ctl_q[`TTC_T3_CNTSEL] ? fall.clkPinIn // R11
                                         : (t3Fast ? halfTick : machTick));
  assign t3Ovf  = t3Inc & (c3_q == `TTC_CNT_MAX);
  assign t3Trig = t3Ctl_q[`TTC_T3_EXTEN] & ~t3Baud & fall.thirdTimerTriggerPin; // R9

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      c3_q <= `TTC_RST_CNT;
    end else if (wrAt(`TTC_A_C3L)) begin
      c3_q <= {c3_q[15:8], hwdata[7:0]};
    end else if (wrAt(`TTC_A_C3H)) begin
      c3_q <= {hwdata[7:0], c3_q[7:0]};
    end else if (t3Ovf) begin
      c3_q <= t3Cap ? `TTC_RST_CNT : rcap_q; // R8 R14
    end else if (t3Trig && !t3Cap) begin
      c3_q <= rcap_q; // R9
    end else if (t3Inc) begin
      c3_q <= c3_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rcap_q <= `TTC_RST_CNT;
    end else if (wrAt(`TTC_A_RLDL)) begin
      rcap_q <= {rcap_q[15:8], hwdata[7:0]};
    end else if (wrAt(`TTC_A_RLDH)) begin
      rcap_q <= {hwdata[7:0], rcap_q[7:0]};
    end else if (t3Trig && t3Cap) begin
      rcap_q <= c3_q; // R9
    end
  end

  // Toggle on each overflow gives equal high and low times
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      clkOut_q <= 1'b0;
      baudTx_q <= 1'b0;
      baudRx_q <= 1'b0;
    end else begin
      if (t3Ovf && t3Aux_q[`TTC_AUX_CLKOE]) clkOut_q <= ~clkOut_q; // R10 R13
      baudTx_q <= t3Ovf & t3Ctl_q[`TTC_T3_TXBAUD]; // R16
      baudRx_q <= t3Ovf & t3Ctl_q[`TTC_T3_RXBAUD];
    end
  end

  assign clkPinOut  = clkOut_q;
  assign clkPinOe   = t3Aux_q[`TTC_AUX_CLKOE] & ~t3Ctl_q[`TTC_T3_CNTSEL]; // R10
  assign baudTxTick = baudTx_q;
  assign baudRxTick = baudRx_q;

  // Sticky status, cleared by a read; a set in the same cycle survives
  always_comb begin
    statSet = '0;
    statSet[`TTC_ST_OVF1]  = st1.ovf; // R17
    statSet[`TTC_ST_OVF2]  = st2.ovf;
    statSet[`TTC_ST_OVF3]  = t3Ovf & ~t3Fast; // R15
    statSet[`TTC_ST_TRIG3] = t3Trig;
    statSet[`TTC_ST_SPLIT] = st1.ovfHi;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stat_q <= '0;
    end else if (rdWait_q && addr_q == `TTC_A_STAT) begin
      stat_q <= statSet;
    end else begin
      stat_q <= stat_q | statSet;
    end
  end

  assign irqOut = |(stat_q & mask_q);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence readAddr;
    accept && !hwrite;
  endsequence
  sequence readData;
    !hreadyout ##1 hreadyout;
  endsequence

  bus_read_wait_a: assert property (readAddr |=> readData) // R1
    else $error("read does not take exactly one wait state");
  t3_ovf_flag_a: assert property (t3Ovf && !t3Fast && !rdWait_q |=> stat_q[`TTC_ST_OVF3]) // R17
    else $error("third timer overflow flag not set");
  clk_no_flag_a: assert property (t3Ovf && t3Fast && !t3Trig |=> !$rose(stat_q[`TTC_ST_OVF3])) // R15
    else $error("clock output overflow raised a flag");
  clk_toggle_a: assert property (t3Ovf && t3Aux_q[`TTC_AUX_CLKOE] |=> clkPinOut != $past(clkPinOut)) // R10
    else $error("clock output did not toggle on overflow");
  reload_word_a: assert property (t3Ovf && !t3Cap && !wrPend_q |=> c3_q == $past(rcap_q)) // R14
    else $error("third timer did not reload high:low word");
  no_trig_hold_a: assert property (!t3Ctl_q[`TTC_T3_EXTEN] && !wrPend_q |=> $stable(rcap_q)) // R8
    else $error("capture happened without trigger enabled");
  trig_capture_a: assert property (t3Trig && t3Cap && !wrPend_q |=> rcap_q == $past(c3_q)) // R9
    else $error("trigger edge did not capture count");
  gate_toggle_a: assert property (ctrlReg_q[`TTC_CTRL_RUN1] && cfg1.gate && fall.firstGatePin // R4
                                  |=> gate1On_q != $past(gate1On_q))
    else $error("first gate did not toggle on falling edge");
  gate2_toggle_a: assert property (ctrlReg_q[`TTC_CTRL_RUN2] && cfg2.gate && fall.secondGatePin // R5
                                   |=> gate2On_q != $past(gate2On_q))
    else $error("second gate did not toggle on falling edge");
  half_rate_a: assert property (!ctrlReg_q[`TTC_CTRL_SIX] && halfTick && !wrPend_q |=> !halfTick) // R13
    else $error("half-rate tick too fast in twelve-clock mode");
  split_stop_a: assert property (cfg2.mode == TTC_MSPLIT && !wrPend_q |=> $stable(c2_q)) // R3
    else $error("second timer ran in mode 3");
  wrap13_a: assert property (cfg1.mode == TTC_M13 && run1 && tick1 && c1_q[15:8] == 8'hFF // R19
                             && c1_q[4:0] == 5'h1F && !wrPend_q
                             |=> c1_q[15:8] == 8'h00 && c1_q[4:0] == 5'h00)
    else $error("13-bit mode did not wrap at 8192");
  count_edge_a: assert property (t3Ctl_q[`TTC_T3_CNTSEL] && t3Ctl_q[`TTC_T3_RUN] // R11
                                 && fall.clkPinIn && !t3Ovf && !t3Trig && !wrPend_q
                                 |=> c3_q == $past(c3_q) + 16'h0001)
    else $error("third counter missed a falling edge");
endmodule

// ---- test/triple_timer_counter_clockout_test.sv ----
// Self-checking bench for the triple timer block: bus, timers, trigger, clock out, baud ticks.
// Assumes ttc_top with hready looped from hreadyout and pins driven synchronously to mclk.
`timescale 1ns/10ps
`include "ttc_regs.svh"
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
  $display("BAD %s exp %h got %h", nm, exp, got); errors++; end end

module triple_timer_counter_clockout_test;
  import ttc_pkg::*;
  logic               mclk;
  logic               reset;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [31:0]        hwdata;
  logic               hreadyout;
  logic               hresp;
  logic [31:0]        hrdata;
  ttc_pins_s          pins;
  logic               clkPinOut;
  logic               clkPinOe;
  logic               baudTxTick;
  logic               baudRxTick;
  logic               irqOut;
  int                 errors;
  int                 samples_checked;
  int                 seed;
  logic [31:0]        rd;
  logic [15:0]        rld;
  logic [7:0]         val;
  int                 n;
  int                 hi;
  int                 lo;
  int                 txN;
  int                 rxN;

  ttc_top uut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
    .clkPinOut(clkPinOut), .clkPinOe(clkPinOe), .baudTxTick(baudTxTick),
    .baudRxTick(baudRxTick), .irqOut(irqOut));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Half period of the output clock in mclk cycles
  function automatic int halfPer(input logic six, input logic [15:0] r);
    halfPer = (six ? 2 : 4) * (65536 - int'(r)) / 2;
  endfunction

  // The ready level seen just before a rising edge is what that edge samples
  task automatic waitReady();
    logic rdy;
    do begin
      @(negedge mclk);
      rdy = hreadyout;
      @(posedge mclk);
    end while (rdy !== 1'b1);
  endtask

  task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    waitReady();
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(negedge mclk);
      rd = hrdata;
      if (hreadyout === 1'b1) begin
        break;
      end
      @(posedge mclk);
    end while (1);
    @(posedge mclk);
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    busXfer(1'b1, a, {24'h000000, d});
  endtask

  task automatic rd8(input logic [7:0] a);
    busXfer(1'b0, a, 32'h00000000);
  endtask

  task automatic pulsePin(input int which);
    repeat (3) @(posedge mclk);
    case (which)
      0: pins.firstGatePin <= 1'b1;
      1: pins.firstCountPin <= 1'b1;
      3: pins.secondGatePin <= 1'b1;
      4: pins.clkPinIn <= 1'b1;
      default: pins.thirdTimerTriggerPin <= 1'b1;
    endcase
    repeat (3) @(posedge mclk);
    pins <= '0;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    test_done();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    seed = 21;
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    pins = '0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    `CHK("resp", 1'b0, hresp)
    `CHK("oe", 1'b0, clkPinOe)
    `CHK("irq", 1'b0, irqOut)
    // Byte-wide count and reload registers, plus an unmapped offset
    for (int a = 8'h10; a <= 8'h2C; a += 4) begin
      val = $random(seed);
      wr8(a[7:0], val);
      rd8(a[7:0]);
      `CHK("byte", {24'h000000, val}, rd)
    end
    wr8(8'h40, 8'hA5);
    rd8(8'h40);
    `CHK("unmapped", 32'h00000000, rd)
    $display("test registers done");
    // First timer 16-bit overflow sets flag and raises unmasked interrupt
    wr8(`TTC_A_MODE, 8'h01);
    wr8(`TTC_A_C1H, 8'hFF);
    wr8(`TTC_A_C1L, 8'hFE);
    wr8(`TTC_A_MASK, 8'h01);
    wr8(`TTC_A_CTRL, 8'h01);
    n = 0;
    while (irqOut !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    `CHK("irq set", 1'b1, irqOut)
    wr8(`TTC_A_CTRL, 8'h00);
    rd8(`TTC_A_STAT);
    `CHK("ovf1", 1'b1, rd[`TTC_ST_OVF1])
    rd8(`TTC_A_STAT);
    `CHK("stat clr", 32'h00000000, rd)
    `CHK("irq clr", 1'b0, irqOut)
    $display("test overflow done");
    // Counter mode counts falling edges of the count pin
    n = 1 + ({$random(seed)} % 8);
    wr8(`TTC_A_MODE, 8'h05);
    wr8(`TTC_A_C1L, 8'h00);
    wr8(`TTC_A_C1H, 8'h00);
    wr8(`TTC_A_CTRL, 8'h01);
    for (int i = 0; i < n; i++) begin
      pulsePin(1);
    end
    rd8(`TTC_A_C1L);
    `CHK("events", n[7:0], rd[7:0])
    // 8-bit auto-reload and 13-bit wrap, each on one count edge
    val = $random(seed);
    wr8(`TTC_A_MODE, 8'h06);
    wr8(`TTC_A_C1H, val);
    wr8(`TTC_A_C1L, 8'hFF);
    pulsePin(1);
    rd8(`TTC_A_C1L);
    `CHK("reload8", val, rd[7:0])
    wr8(`TTC_A_MODE, 8'h04);
    wr8(`TTC_A_C1H, 8'hFF);
    wr8(`TTC_A_C1L, 8'h1F);
    pulsePin(1);
    rd8(`TTC_A_C1H);
    `CHK("wrap13", 8'h00, rd[7:0])
    $display("test counter done");
    // Gated timer stays stopped until a gate pin falling edge
    wr8(`TTC_A_CTRL, 8'h00);
    wr8(`TTC_A_MODE, 8'h09);
    wr8(`TTC_A_C1L, 8'h00);
    wr8(`TTC_A_CTRL, 8'h01);
    repeat (60) @(posedge mclk);
    rd8(`TTC_A_C1L);
    `CHK("gated hold", 8'h00, rd[7:0])
    pulsePin(0);
    repeat (60) @(posedge mclk);
    rd8(`TTC_A_C1L);
    `CHK("gated run", 1'b1, rd[7:0] != 8'h00)
    // Second timer mode 3 does not run
    wr8(`TTC_A_MODE, 8'h30);
    wr8(`TTC_A_C2L, 8'h00);
    wr8(`TTC_A_CTRL, 8'h02);
    repeat (60) @(posedge mclk);
    rd8(`TTC_A_C2L);
    `CHK("mode3 hold", 8'h00, rd[7:0])
    // Second timer gated: stopped until its gate pin falls
    wr8(`TTC_A_MODE, 8'h90);
    repeat (60) @(posedge mclk);
    rd8(`TTC_A_C2L);
    `CHK("gate2 hold", 8'h00, rd[7:0])
    pulsePin(3);
    repeat (60) @(posedge mclk);
    rd8(`TTC_A_C2L);
    `CHK("gate2 run", 1'b1, rd[7:0] != 8'h00)
    wr8(`TTC_A_CTRL, 8'h00);
    $display("test gate done");
    // Trigger reload with external enable, masked interrupt
    rld = $random(seed);
    wr8(`TTC_A_MASK, 8'h00);
    wr8(`TTC_A_RLDL, rld[7:0]);
    wr8(`TTC_A_RLDH, rld[15:8]);
    wr8(`TTC_A_C3L, 8'h00);
    wr8(`TTC_A_C3H, 8'h00);
    wr8(`TTC_A_T3CTL, 8'h0A);
    wr8(`TTC_A_T3CTL, 8'h0E);
    pulsePin(2);
    rd8(`TTC_A_C3L);
    `CHK("trig lo", rld[7:0], rd[7:0])
    rd8(`TTC_A_C3H);
    `CHK("trig hi", rld[15:8], rd[7:0])
    `CHK("masked irq", 1'b0, irqOut)
    rd8(`TTC_A_STAT);
    `CHK("trig flag", 1'b1, rd[`TTC_ST_TRIG3])
    wr8(`TTC_A_T3CTL, 8'h06);
    wr8(`TTC_A_C3L, 8'h00);
    pulsePin(2);
    rd8(`TTC_A_C3L);
    `CHK("no trig", 8'h00, rd[7:0])
    pulsePin(4);
    rd8(`TTC_A_C3L);
    `CHK("ext count", 8'h01, rd[7:0])
    $display("test trigger done");
    // Baud tick selection for each baud code
    wr8(`TTC_A_RLDL, 8'hFF);
    wr8(`TTC_A_RLDH, 8'hFF);
    // Start at the top so the first overflow comes at once
    wr8(`TTC_A_C3L, 8'hFF);
    wr8(`TTC_A_C3H, 8'hFF);
    for (int k = 0; k < 3; k++) begin
      val = (k == 0) ? 8'h34 : (k == 1) ? 8'h24 : 8'h14;
      wr8(`TTC_A_T3CTL, val);
      // A tick launched under the previous code may still stand for one cycle
      @(posedge mclk);
      txN = 0;
      rxN = 0;
      repeat (40) begin
        @(negedge mclk);
        txN += (baudTxTick === 1'b1);
        rxN += (baudRxTick === 1'b1);
      end
      `CHK("tx tick", val[4], txN > 0)
      `CHK("rx tick", val[5], rxN > 0)
    end
    wr8(`TTC_A_T3CTL, 8'h00);
    $display("test baud done");
    // Clock output period in twelve-clock mode alone and in six-clock mode beside baud generation
    rd8(`TTC_A_STAT);
    for (int k = 0; k < 2; k++) begin
      rld = 16'hFFF8 | ({$random(seed)} % 7);
      wr8(`TTC_A_CTRL, k == 1 ? 8'h10 : 8'h00);
      wr8(`TTC_A_RLDL, rld[7:0]);
      wr8(`TTC_A_RLDH, rld[15:8]);
      wr8(`TTC_A_T3AUX, 8'h02);
      wr8(`TTC_A_T3CTL, k == 1 ? 8'h34 : 8'h04);
      n = 0;
      @(negedge mclk);
      `CHK("oe on", 1'b1, clkPinOe)
      while (clkPinOut !== 1'b0 && n < 100) begin @(negedge mclk); n++; end
      while (clkPinOut !== 1'b1 && n < 100) begin @(negedge mclk); n++; end
      hi = 0;
      lo = 0;
      while (clkPinOut === 1'b1 && hi < 100) begin @(negedge mclk); hi++; end
      while (clkPinOut === 1'b0 && lo < 100) begin @(negedge mclk); lo++; end
      `CHK("clk high", halfPer(k == 1, rld), hi)
      `CHK("clk low", halfPer(k == 1, rld), lo)
      rd8(`TTC_A_STAT);
      `CHK("no ovf3", 1'b0, rd[`TTC_ST_OVF3])
    end
    $display("test clock out done");
    test_done();
  end
endmodule
